// ===== hdl/dcp_defines.svh
// Register offsets, field positions, reset values and timing constants
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
`define DCP_ADDR_W          6
`define DCP_DATA_W          16
`define DCP_OFF_REF_TRIM    6'h03
`define DCP_OFF_OUT_GAIN    6'h07
`define DCP_OFF_GAIN_SPAN   6'h08
`define DCP_OFF_SET_RES     6'h0C
`define DCP_OFF_CAL_CTRL    6'h0D
`define DCP_OFF_CMP_TRIM    6'h0E
`define DCP_OFF_COMMIT      6'h1D
`define DCP_OFF_PAT_STATE   6'h1E
`define DCP_RST_REF_TRIM    16'h0000
`define DCP_RST_OUT_GAIN    16'h0000
`define DCP_RST_GAIN_SPAN   16'h0000
`define DCP_RST_SET_RES     16'h000A
`define DCP_RST_CAL_CTRL    16'h0000
`define DCP_RST_CMP_TRIM    16'h0000
`define DCP_RST_COMMIT      16'h0000
`define DCP_RST_PAT_STATE   16'h0000
`define DCP_CAL_START_BIT   0
`define DCP_CAL_DONE_BIT    1
`define DCP_CAL_DIV_LSB     0
`define DCP_CAL_CLKEN_BIT   3
`define DCP_CAL_EN_BIT      6
`define DCP_CAL_INUSE_BIT   7
`define DCP_CAL_RESET_BIT   8
`define DCP_RES_EN_BIT      15
`define DCP_COMMIT_BIT      0
`define DCP_PAT_RUN_BIT     0
`define DCP_PAT_PLAY_BIT    1
`define DCP_PAT_MEM_BIT     2
`define DCP_PAT_BUF_BIT     3
`define DCP_CAL_STEPS       4'h8
`define DCP_SPEC_RW_MASK    16'h0000
`endif

// ===== hdl/dcp_pkg.sv
// Types shared by the calibration and pattern register bank
package dcp_pkg;
   typedef logic [15:0] dcp_word_t;
   typedef enum logic [1:0] {
      DCP_CAL_IDLE = 2'b00,
      DCP_CAL_RUN  = 2'b01,
      DCP_CAL_DONE = 2'b10
   } dcp_cal_state_t;
endpackage

// ===== hdl/dcp_shadow_bank.sv
// Active (committed) copy of the register file, eight words with registered read
`include "dcp_defines.svh"
module dcp_shadow_bank (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Commit port
   input  wire logic              commit,
   input  wire dcp_pkg::dcp_word_t pend_words [8],
   // Read port
   input  wire logic [2:0]        rd_idx,
   output dcp_pkg::dcp_word_t     rd_data,
   output dcp_pkg::dcp_word_t     act_words [8]
);
   import dcp_pkg::*;
   dcp_word_t mem_r [8];
   dcp_word_t rd_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_r[0] <= `DCP_RST_REF_TRIM;
         mem_r[1] <= `DCP_RST_OUT_GAIN;
         mem_r[2] <= `DCP_RST_GAIN_SPAN;
         mem_r[3] <= `DCP_RST_SET_RES;
         mem_r[4] <= `DCP_RST_CAL_CTRL;
         mem_r[5] <= `DCP_RST_CMP_TRIM;
         mem_r[6] <= `DCP_RST_COMMIT;
         mem_r[7] <= `DCP_RST_PAT_STATE;
         rd_r     <= 16'h0000;
      end else begin
         if (commit) begin
            mem_r <= pend_words;
         end
         rd_r <= mem_r[rd_idx];
      end
   end
   assign rd_data  = rd_r;
   assign act_words = mem_r;
endmodule

// ===== hdl/dcp_reg_bank.sv
// Calibration, gain, resistor and pattern-control register bank of the DAC
`include "dcp_defines.svh"
// Notes on behaviour
// - Six-bit reference trim, resets to zero
// - Seven-bit gain applies outside calibration mode
// - Calibrated gain field read-only, writes ignored
// - Two-bit gain span field, resets zero
// - Bit 15 enables internal resistor, reads status
// - Five-bit resistor setting, resets to ten
// - Calibrated resistor value read-only field
// - Six read-only overflow/underflow result flags
// - In-use flag set while results used
// - Enable bit switches on calibration circuitry
// - Clock enable bit gates calibration activity
// - Calibration clock divides by three-bit setting plus one
// - Offset result in read-only seven-bit field
// - Done flag set when calibration completes
// - Writing start bit launches calibration
// - Update bit commits settings, self-clears
// - Buffer readback bit selects active copy
// - Memory access only with enable bit
// - Playing status high while pattern plays
// - Run bit permits pattern, run low stops at pattern end
// - Software reset reloads defaults except register zero
module dcp_reg_bank (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              soft_reset,
   // Register port from the serial interface, same clock domain
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [5:0]        reg_addr,
   input  wire dcp_pkg::dcp_word_t reg_wdata,
   output dcp_pkg::dcp_word_t     reg_rdata,
   output logic                   reg_rvalid,
   // Pattern engine
   input  wire logic              pat_trigger,
   input  wire logic              pat_end,
   input  wire logic              mem_req,
   output logic                   mem_grant,
   output logic                   pat_playing,
   // Analog settings out
   output logic [5:0]             reference_level_trim,
   output logic [6:0]             gain_setting,
   output logic [1:0]             gain_span_select,
   output logic                   internal_resistor_enable,
   output logic [4:0]             resistor_value_setting,
   output logic [1:0]             offset_trim_span,
   output logic                   cal_clock_tick,
   // Analog calibration results in
   input  wire logic              cal_cmp,
   input  wire logic [6:0]        cal_gain_in,
   input  wire logic [4:0]        cal_res_in,
   input  wire logic [6:0]        cal_offset_in,
   input  wire logic [5:0]        cal_flow_in
);
   import dcp_pkg::*;

   // Pending copies, index order follows the eight offsets
   dcp_word_t      pend_r [8];
   dcp_word_t      pend_nxt [8];
   dcp_word_t      act_w [8];
   dcp_word_t      act_rd_w;
   dcp_cal_state_t cal_st_r;
   dcp_cal_state_t cal_st_nxt;
   logic [2:0]     div_cnt_r;
   logic [3:0]     step_r;
   logic           tick_r;
   logic           cal_done_r;
   logic           cal_inuse_r;
   logic           cal_rst_q_r;
   logic [6:0]     gain_res_r;
   logic [4:0]     res_res_r;
   logic [6:0]     off_res_r;
   logic [5:0]     flow_r;
   logic           cmp_s1_r;
   logic           cmp_s2_r;
   logic           playing_r;
   logic           commit_r;
   logic           rd_hit_r;
   logic           rd_buf_r;
   logic           rd_stage_r;
   dcp_word_t      rd_pend_data_r;
   dcp_word_t      rdata_r;
   logic           rvalid_r;
   logic [5:0]     ref_r;
   logic [6:0]     gain_r;
   logic [1:0]     span_r;
   logic           resen_r;
   logic [4:0]     resv_r;
   logic [1:0]     offspan_r;
   logic           grant_r;

   function automatic logic [3:0] addr_idx(input logic [5:0] a);
      case (a)
         `DCP_OFF_REF_TRIM:  addr_idx = 4'h0;
         `DCP_OFF_OUT_GAIN:  addr_idx = 4'h1;
         `DCP_OFF_GAIN_SPAN: addr_idx = 4'h2;
         `DCP_OFF_SET_RES:   addr_idx = 4'h3;
         `DCP_OFF_CAL_CTRL:  addr_idx = 4'h4;
         `DCP_OFF_CMP_TRIM:  addr_idx = 4'h5;
         `DCP_OFF_COMMIT:    addr_idx = 4'h6;
         `DCP_OFF_PAT_STATE: addr_idx = 4'h7;
         default:            addr_idx = 4'h8;
      endcase
   endfunction

   // Hardware-owned bits per index; host writes never reach them
   function automatic dcp_word_t ro_mask(input logic [2:0] i);
      case (i)
         3'h1:    ro_mask = 16'h7F00;
         3'h3:    ro_mask = 16'h1F00;
         3'h4:    ro_mask = 16'h7E80;
         3'h5:    ro_mask = 16'h7F02;
         3'h7:    ro_mask = 16'h0002;
         default: ro_mask = 16'h0000;
      endcase
   endfunction

   wire logic [3:0] wr_idx_w   = addr_idx(reg_addr);
   wire logic       wr_hit_w   = reg_wr && !wr_idx_w[3];
   wire dcp_word_t  cal_ctl_w  = pend_r[4];
   wire logic       cal_en_w   = cal_ctl_w[`DCP_CAL_EN_BIT];
   wire logic       cal_clk_w  = cal_ctl_w[`DCP_CAL_CLKEN_BIT];
   wire logic [2:0] cal_div_w  = cal_ctl_w[2:0];
   wire logic       cal_rst_w  = cal_ctl_w[`DCP_CAL_RESET_BIT];
   wire logic       cal_rst_fall_w = cal_rst_q_r && !cal_rst_w;
   wire logic       start_wr_w = wr_hit_w && (wr_idx_w[2:0] == 3'h5)
                                 && reg_wdata[`DCP_CAL_START_BIT];
   wire logic       commit_wr_w = wr_hit_w && (wr_idx_w[2:0] == 3'h6)
                                  && reg_wdata[`DCP_COMMIT_BIT];
   wire logic       run_w      = act_w[7][`DCP_PAT_RUN_BIT];
   wire logic       mem_en_w   = act_w[7][`DCP_PAT_MEM_BIT];
   wire logic       buf_rd_w   = pend_r[7][`DCP_PAT_BUF_BIT];
   wire logic       step_w     = tick_r && (cal_st_r == DCP_CAL_RUN);

   // Hardware fields folded over the stored words
   always_comb begin
      pend_nxt = pend_r;
      if (wr_hit_w) begin
         pend_nxt[wr_idx_w[2:0]] = (reg_wdata & ~ro_mask(wr_idx_w[2:0]))
                                  | (pend_r[wr_idx_w[2:0]] & ro_mask(wr_idx_w[2:0]));
      end
      pend_nxt[1][14:8]  = gain_res_r;
      pend_nxt[3][12:8]  = res_res_r;
      pend_nxt[4][14:9]  = flow_r;
      pend_nxt[4][`DCP_CAL_INUSE_BIT] = cal_inuse_r;
      pend_nxt[5][14:8]  = off_res_r;
      pend_nxt[5][`DCP_CAL_DONE_BIT] = cal_done_r;
      pend_nxt[5][`DCP_CAL_START_BIT] = 1'b0;
      pend_nxt[6][`DCP_COMMIT_BIT] = 1'b0;
      pend_nxt[7][`DCP_PAT_PLAY_BIT] = playing_r;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pend_r[0] <= `DCP_RST_REF_TRIM;
         pend_r[1] <= `DCP_RST_OUT_GAIN;
         pend_r[2] <= `DCP_RST_GAIN_SPAN;
         pend_r[3] <= `DCP_RST_SET_RES;
         pend_r[4] <= `DCP_RST_CAL_CTRL;
         pend_r[5] <= `DCP_RST_CMP_TRIM;
         pend_r[6] <= `DCP_RST_COMMIT;
         pend_r[7] <= `DCP_RST_PAT_STATE;
      end else if (soft_reset) begin
         // Configuration word at zero lives outside this bank, so all eight reload
         pend_r[0] <= `DCP_RST_REF_TRIM;
         pend_r[1] <= `DCP_RST_OUT_GAIN;
         pend_r[2] <= `DCP_RST_GAIN_SPAN;
         pend_r[3] <= `DCP_RST_SET_RES;
         pend_r[4] <= `DCP_RST_CAL_CTRL;
         pend_r[5] <= `DCP_RST_CMP_TRIM;
         pend_r[6] <= `DCP_RST_COMMIT;
         pend_r[7] <= `DCP_RST_PAT_STATE;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // Commit pulse copies pending words into the active bank
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         commit_r <= 1'b0;
      end else begin
         commit_r <= commit_wr_w;
      end
   end

   // Active bank reloads its own defaults on a software reset, never stale pending words
   // Read address goes in unregistered so the active word lands with the pending one
   dcp_shadow_bank u_shadow (
      .clock      (clock),
      .rst        (rst || soft_reset),
      .commit     (commit_r),
      .pend_words (pend_nxt),
      .rd_idx     (wr_idx_w[2:0]),
      .rd_data    (act_rd_w),
      .act_words  (act_w)
   );

   // Calibration clock divider; a tick every div+1 cycles, only when gated on
   always_ff @(posedge clock) begin
      if (rst || soft_reset || !cal_clk_w) begin
         div_cnt_r <= 3'h0;
         tick_r    <= 1'b0;
      end else if (div_cnt_r == cal_div_w) begin
         div_cnt_r <= 3'h0;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 3'h1;
         tick_r    <= 1'b0;
      end
   end

   // Comparator is analog, sampled through two flops
   always_ff @(posedge clock) begin
      if (rst) begin
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
      end else begin
         cmp_s1_r <= cal_cmp;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   always_comb begin
      cal_st_nxt = cal_st_r;
      case (cal_st_r)
         DCP_CAL_IDLE: begin
            if (start_wr_w && cal_en_w && cal_clk_w) begin
               cal_st_nxt = DCP_CAL_RUN;
            end
         end
         DCP_CAL_RUN: begin
            if (!cal_en_w) begin
               cal_st_nxt = DCP_CAL_IDLE;
            end else if (step_w && step_r == `DCP_CAL_STEPS) begin
               cal_st_nxt = DCP_CAL_DONE;
            end
         end
         DCP_CAL_DONE: begin
            if (start_wr_w && cal_en_w && cal_clk_w) begin
               cal_st_nxt = DCP_CAL_RUN;
            end else if (cal_rst_fall_w) begin
               cal_st_nxt = DCP_CAL_IDLE;
            end
         end
         default: cal_st_nxt = DCP_CAL_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         cal_st_r    <= DCP_CAL_IDLE;
         step_r      <= 4'h0;
         cal_done_r  <= 1'b0;
         cal_inuse_r <= 1'b0;
         cal_rst_q_r <= 1'b0;
         gain_res_r  <= 7'h00;
         res_res_r   <= 5'h00;
         off_res_r   <= 7'h00;
         flow_r      <= 6'h00;
      end else begin
         cal_st_r    <= cal_st_nxt;
         cal_rst_q_r <= cal_rst_w;
         if (cal_st_r != DCP_CAL_RUN) begin
            step_r <= 4'h0;
         end else if (step_w && cmp_s2_r) begin
            step_r <= step_r + 4'h1;
         end else if (step_w) begin
            step_r <= step_r + 4'h1;
         end
         // Completion wins over a results clear landing in the same cycle
         if (cal_st_r == DCP_CAL_RUN && cal_st_nxt == DCP_CAL_DONE) begin
            gain_res_r  <= cal_gain_in;
            res_res_r   <= cal_res_in;
            off_res_r   <= cal_offset_in;
            flow_r      <= cal_flow_in;
            cal_done_r  <= 1'b1;
            cal_inuse_r <= cal_en_w;
         end else if (cal_rst_fall_w) begin
            gain_res_r  <= 7'h00;
            res_res_r   <= 5'h00;
            off_res_r   <= 7'h00;
            flow_r      <= 6'h00;
            cal_done_r  <= 1'b0;
            cal_inuse_r <= 1'b0;
         end else if (cal_st_nxt == DCP_CAL_RUN) begin
            cal_done_r  <= 1'b0;
         end
         if (!cal_en_w) begin
            cal_inuse_r <= 1'b0;
         end
      end
   end

   // Pattern play status: a trigger starts it while run is set; run low stops at end
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         playing_r <= 1'b0;
      end else if (!playing_r && run_w && pat_trigger) begin
         playing_r <= 1'b1;
      end else if (playing_r && pat_end && !run_w) begin
         playing_r <= 1'b0;
      end
   end

   // Read path: two cycles so the active bank read can land
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_hit_r       <= 1'b0;
         rd_buf_r       <= 1'b0;
         rd_stage_r     <= 1'b0;
         rd_pend_data_r <= 16'h0000;
         rdata_r        <= 16'h0000;
         rvalid_r       <= 1'b0;
      end else begin
         rd_stage_r <= reg_rd;
         if (reg_rd) begin
            rd_hit_r       <= !wr_idx_w[3];
            rd_buf_r       <= buf_rd_w;
            rd_pend_data_r <= wr_idx_w[3] ? 16'h0000 : pend_r[wr_idx_w[2:0]];
         end
         rvalid_r <= rd_stage_r;
         if (rd_stage_r) begin
            rdata_r <= !rd_hit_r ? 16'h0000 :
                       rd_buf_r  ? act_rd_w : rd_pend_data_r;
         end
      end
   end

   // Analog controls follow the active bank, gain and resistor value take calibration results while in use
   always_ff @(posedge clock) begin
      if (rst) begin
         ref_r     <= 6'h00;
         gain_r    <= 7'h00;
         span_r    <= 2'h0;
         resen_r   <= 1'b0;
         resv_r    <= 5'h0A;
         offspan_r <= 2'h0;
         grant_r   <= 1'b0;
      end else begin
         ref_r     <= act_w[0][5:0];
         gain_r    <= cal_inuse_r ? gain_res_r : act_w[1][6:0];
         span_r    <= act_w[2][1:0];
         resen_r   <= act_w[3][`DCP_RES_EN_BIT];
         resv_r    <= cal_inuse_r ? res_res_r : act_w[3][4:0];
         offspan_r <= act_w[4][5:4];
         grant_r   <= mem_req && mem_en_w;
      end
   end

   assign reg_rdata                = rdata_r;
   assign reg_rvalid               = rvalid_r;
   assign mem_grant                = grant_r;
   assign pat_playing              = playing_r;
   assign reference_level_trim     = ref_r;
   assign gain_setting             = gain_r;
   assign gain_span_select         = span_r;
   assign internal_resistor_enable = resen_r;
   assign resistor_value_setting   = resv_r;
   assign offset_trim_span         = offspan_r;
   assign cal_clock_tick           = tick_r;

   property p_commit_clears;
      @(posedge clock) disable iff (rst || soft_reset)
      commit_wr_w |=> commit_r && pend_r[6][0] == 1'b0;
   endproperty
   a_commit_clears: assert property (p_commit_clears) else $error("commit bit stuck");

   property p_grant;
      @(posedge clock) disable iff (rst)
      grant_r |-> $past(mem_req) && $past(mem_en_w);
   endproperty
   a_grant: assert property (p_grant) else $error("memory grant without enable");

   property p_no_tick_gated;
      @(posedge clock) disable iff (rst)
      !cal_clk_w ##1 !cal_clk_w |-> !tick_r;
   endproperty
   a_no_tick_gated: assert property (p_no_tick_gated) else $error("tick while gated");

   property p_ro_gain;
      @(posedge clock) disable iff (rst || soft_reset)
      ##1 pend_r[1][14:8] == $past(gain_res_r);
   endproperty
   a_ro_gain: assert property (p_ro_gain) else $error("gain result field written");

   property p_done_flag;
      @(posedge clock) disable iff (rst || soft_reset)
      cal_st_r == DCP_CAL_DONE |-> cal_done_r;
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag missing");

   property p_stop_run;
      @(posedge clock) disable iff (rst || soft_reset)
      playing_r && pat_end && !run_w |=> !playing_r;
   endproperty
   a_stop_run: assert property (p_stop_run) else $error("pattern did not stop");

   property p_cal_off;
      @(posedge clock) disable iff (rst || soft_reset)
      !cal_en_w |=> cal_st_r != DCP_CAL_RUN;
   endproperty
   a_cal_off: assert property (p_cal_off) else $error("calibration ran disabled");

   property p_rst_clear;
      @(posedge clock) disable iff (rst || soft_reset)
      cal_rst_fall_w |=> flow_r == 6'h00 && !cal_done_r;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("results not cleared");

   c_cal_done: cover property (@(posedge clock) cal_st_r == DCP_CAL_DONE);
   c_play:     cover property (@(posedge clock) playing_r);
   c_commit:   cover property (@(posedge clock) commit_r);
endmodule

// ===== bench/dcp_host_model.sv
// Host model that issues single register writes and reads
module dcp_host_model (
   // Clock
   input  wire logic               clock,
   // Register port
   output logic                    reg_wr,
   output logic                    reg_rd,
   output logic [5:0]              reg_addr,
   output dcp_pkg::dcp_word_t      reg_wdata,
   input  wire dcp_pkg::dcp_word_t reg_rdata,
   input  wire logic               reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   import dcp_pkg::*;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
   end
   // One strobe per call; released lines show the inverse, never the old value
   task automatic wr(input logic [5:0] a, input dcp_word_t d);
      @(posedge clock);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output dcp_word_t d);
      int n;
      @(posedge clock);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
   endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench for the calibration and pattern register bank
`include "dcp_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dcp_pkg::*;
   logic       clock, rst, soft_reset, reg_wr, reg_rd, reg_rvalid;
   logic       pat_trigger, pat_end, mem_req, mem_grant, pat_playing;
   logic       internal_resistor_enable, cal_clock_tick, cal_cmp;
   logic [5:0] reg_addr, reference_level_trim, cal_flow_in;
   logic [6:0] gain_setting, cal_gain_in, cal_offset_in;
   logic [4:0] resistor_value_setting, cal_res_in;
   logic [1:0] gain_span_select, offset_trim_span;
   dcp_word_t  reg_wdata, reg_rdata;
   int         n_fail, compares;
   dcp_reg_bank i_dut (.clock(clock), .rst(rst), .soft_reset(soft_reset), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pat_trigger(pat_trigger), .pat_end(pat_end),
      .mem_req(mem_req), .mem_grant(mem_grant), .pat_playing(pat_playing),
      .reference_level_trim(reference_level_trim), .gain_setting(gain_setting),
      .gain_span_select(gain_span_select), .internal_resistor_enable(internal_resistor_enable),
      .resistor_value_setting(resistor_value_setting), .offset_trim_span(offset_trim_span),
      .cal_clock_tick(cal_clock_tick), .cal_cmp(cal_cmp), .cal_gain_in(cal_gain_in),
      .cal_res_in(cal_res_in), .cal_offset_in(cal_offset_in), .cal_flow_in(cal_flow_in));
   dcp_host_model i_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(input dcp_word_t seen, input dcp_word_t exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [5:0] a, input dcp_word_t m, input dcp_word_t e);
      dcp_word_t d;
      i_host.rd(a, d);
      check(d & m, e);
   endtask
   // Settings reach the outputs two edges after the commit write is taken
   task automatic commit();
      i_host.wr(`DCP_OFF_COMMIT, 16'h0001);
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic t_reset_values();
      rdchk(`DCP_OFF_REF_TRIM, 16'hFFFF, 16'h0000);
      rdchk(`DCP_OFF_OUT_GAIN, 16'hFFFF, 16'h0000);
      rdchk(`DCP_OFF_GAIN_SPAN, 16'hFFFF, 16'h0000);
      rdchk(`DCP_OFF_SET_RES, 16'hFFFF, 16'h000A);
      rdchk(`DCP_OFF_CAL_CTRL, 16'hFFFF, 16'h0000);
      rdchk(`DCP_OFF_CMP_TRIM, 16'hFFFF, 16'h0000);
      rdchk(`DCP_OFF_PAT_STATE, 16'hFFFF, 16'h0000);
      check({11'h000, resistor_value_setting}, 16'h000A);
      $display("reset values done");
   endtask
   task automatic t_write_commit();
      i_host.wr(`DCP_OFF_REF_TRIM, 16'hFC3F);
      i_host.wr(`DCP_OFF_OUT_GAIN, 16'hFFD5);
      i_host.wr(`DCP_OFF_GAIN_SPAN, 16'h0003);
      i_host.wr(`DCP_OFF_SET_RES, 16'h801F);
      cyc(2);
      check({10'h000, reference_level_trim}, 16'h0000);
      rdchk(`DCP_OFF_REF_TRIM, 16'hFFFF, 16'hFC3F);
      rdchk(`DCP_OFF_OUT_GAIN, 16'hFFFF, 16'h80D5);
      rdchk(`DCP_OFF_SET_RES, 16'h1FFF, 16'h001F);
      commit();
      check({10'h000, reference_level_trim}, 16'h003F);
      check({9'h000, gain_setting}, 16'h0055);
      check({14'h0000, gain_span_select}, 16'h0003);
      check({15'h0000, internal_resistor_enable}, 16'h0001);
      check({11'h000, resistor_value_setting}, 16'h001F);
      rdchk(`DCP_OFF_COMMIT, 16'h0001, 16'h0000);
      i_host.wr(6'h3F, 16'hFFFF);
      rdchk(6'h3F, 16'hFFFF, 16'h0000);
      $display("write and commit done");
   endtask
   task automatic t_buf_read();
      i_host.wr(`DCP_OFF_PAT_STATE, 16'h0008);
      i_host.wr(`DCP_OFF_REF_TRIM, 16'h0011);
      rdchk(`DCP_OFF_REF_TRIM, 16'hFFFF, 16'hFC3F);
      i_host.wr(`DCP_OFF_PAT_STATE, 16'h0000);
      rdchk(`DCP_OFF_REF_TRIM, 16'hFFFF, 16'h0011);
      $display("buffer readback done");
   endtask
   task automatic count_ticks(input dcp_word_t cfg, input int exp);
      int n;
      i_host.wr(`DCP_OFF_CAL_CTRL, cfg);
      commit();
      n = 0;
      repeat (40) begin
         cyc(1);
         if (cal_clock_tick === 1'b1) n++;
      end
      check(16'(n), 16'(exp));
   endtask
   task automatic t_cal_clock();
      count_ticks(16'h000B, 10);
      count_ticks(16'h0003, 0);
      i_host.wr(`DCP_OFF_CAL_CTRL, 16'h0008);
      commit();
      i_host.wr(`DCP_OFF_CMP_TRIM, 16'h0001);
      commit();
      cyc(60);
      rdchk(`DCP_OFF_CMP_TRIM, 16'h0002, 16'h0000);
      $display("cal clock done");
   endtask
   task automatic t_calibrate();
      dcp_word_t d;
      int n;
      i_host.wr(`DCP_OFF_CAL_CTRL, 16'h0078);
      commit();
      check({14'h0000, offset_trim_span}, 16'h0003);
      i_host.wr(`DCP_OFF_CMP_TRIM, 16'h0001);
      commit();
      d = 16'h0000;
      for (n = 0; n < 50 && d[1] !== 1'b1; n++) i_host.rd(`DCP_OFF_CMP_TRIM, d);
      check(d & 16'h7F02, 16'h3302);
      rdchk(`DCP_OFF_CAL_CTRL, 16'h7E80, 16'h2A80);
      rdchk(`DCP_OFF_OUT_GAIN, 16'h7F00, 16'h1200);
      rdchk(`DCP_OFF_SET_RES, 16'h1F00, 16'h0700);
      cyc(4);
      check({9'h000, gain_setting}, 16'h0012);
      i_host.wr(`DCP_OFF_CAL_CTRL, 16'h0148);
      i_host.wr(`DCP_OFF_CAL_CTRL, 16'h0048);
      cyc(2);
      rdchk(`DCP_OFF_CMP_TRIM, 16'h7F00, 16'h0000);
      $display("calibration done");
   endtask
   task automatic t_pattern();
      mem_req = 1'b1;
      i_host.wr(`DCP_OFF_PAT_STATE, 16'h0005);
      commit();
      check({15'h0000, mem_grant}, 16'h0001);
      pat_trigger = 1'b1;
      cyc(1);
      pat_trigger = 1'b0;
      cyc(1);
      check({15'h0000, pat_playing}, 16'h0001);
      rdchk(`DCP_OFF_PAT_STATE, 16'h0002, 16'h0002);
      i_host.wr(`DCP_OFF_PAT_STATE, 16'h0000);
      commit();
      check({15'h0000, pat_playing}, 16'h0001);
      check({15'h0000, mem_grant}, 16'h0000);
      pat_end = 1'b1;
      cyc(1);
      pat_end = 1'b0;
      cyc(1);
      check({15'h0000, pat_playing}, 16'h0000);
      $display("pattern done");
   endtask
   task automatic t_soft_reset();
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      cyc(3);
      rdchk(`DCP_OFF_SET_RES, 16'hFFFF, 16'h000A);
      rdchk(`DCP_OFF_REF_TRIM, 16'hFFFF, 16'h0000);
      check({11'h000, resistor_value_setting}, 16'h000A);
      $display("soft reset done");
   endtask
   task automatic report_and_stop();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Whole sequence needs a few hundred cycles; limit leaves ample margin
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      soft_reset = 1'b0;
      pat_trigger = 1'b0;
      pat_end = 1'b0;
      mem_req = 1'b0;
      cal_cmp = 1'b0;
      cal_gain_in = 7'h12;
      cal_res_in = 5'h07;
      cal_offset_in = 7'h33;
      cal_flow_in = 6'h15;
      n_fail = 0;
      compares = 0;
      repeat (3) @(posedge clock);
      #1;
      rst = 1'b0;
      t_reset_values();
      t_write_commit();
      t_buf_read();
      t_cal_clock();
      t_calibrate();
      t_pattern();
      t_soft_reset();
      report_and_stop();
   end
endmodule
